// ---- hw/bridge_qos_issue_sync_regs.v ----
// control register bank for a slave-side interface block and an
// internal bridge block, reached over one AHB-Lite slave port
// assumes one clock; the bus is a single-master AHB-Lite segment
//
// Behaviour
// RULE1: slave-side read priority level, 4 bits read/write, resets to zero.
// RULE2: slave-side write priority level, 4 bits read/write, resets to zero.
// RULE3: both priority registers exist only when priority is programmable.
// RULE4: programmable priority registers take a configured reset value.
// RULE5: slave-side 2-bit override limits a direction to one outstanding.
// RULE6: override bit 0 is read, bit 1 is write, active high, reset 0.
// RULE7: bridge 2-bit override forces preceding switch issuing to one.
// RULE8: bridge override bit 0 read, bit 1 write, active high, reset 0.
// RULE9: 3-bit crossing select exists when crossing programmable, resets 4.
// RULE10: crossing codes: 0 1:1, 1 m:1, 2 1:n, 3 m:n, 4 async.
// RULE11: software must not program crossing codes 5, 6 or 7.
// RULE12: reserved offsets read zero and ignore writes.
`timescale 1ns/1ps
`include "bridge_regs_consts.vh"

module bridge_qos_issue_sync_regs #(
  parameter                  QOS_PROGRAMMABLE      = 1,
  parameter [`PRIO_W-1:0]    READ_PRIO_RESET       = `PRIO_RST,
  parameter [`PRIO_W-1:0]    WRITE_PRIO_RESET      = `PRIO_RST,
  parameter                  CROSSING_PROGRAMMABLE = 1
) (
  // clock and reset
  input  wire                 SYS_CLK,
  input  wire                 ARST_N,
  // ahb-lite slave
  input  wire                 HSEL,
  input  wire [31:0]          HADDR,
  input  wire [1:0]           HTRANS,
  input  wire                 HWRITE,
  input  wire [2:0]           HSIZE,
  input  wire [31:0]          HWDATA,
  input  wire                 HREADY,
  output reg  [31:0]          HRDATA,
  output reg                  HREADYOUT,
  output reg                  HRESP,
  // slave-side interface block controls
  output wire [`PRIO_W-1:0]   READ_PRIORITY_LEVEL,
  output wire [`PRIO_W-1:0]   WRITE_PRIORITY_LEVEL,
  output reg                  READ_ISSUE_LIMIT,
  output reg                  WRITE_ISSUE_LIMIT,
  // internal bridge block controls
  output reg                  SWITCH_READ_ISSUE_LIMIT,
  output reg                  SWITCH_WRITE_ISSUE_LIMIT,
  output wire [`CROSS_W-1:0]  CROSSING_SCHEME,
  output reg  [4:0]           CROSSING_SEL
);

  ////////////////////////////////////////////////////////////////////////////
  // bus address and data phase

  wire        addr_phase;
  wire        rd_req;
  wire        wr_req;
  wire [1:0]  req_win;
  wire [11:0] req_ofs;
  wire        req_upper_zero;

  reg         wr_pend_r;
  reg  [1:0]  wr_win_r;
  reg  [11:0] wr_ofs_r;
  reg         wr_word_r;
  reg         wr_hi_ok_r;

  assign addr_phase     = HSEL & HREADY & HTRANS[`HTRANS_NONSEQ_BIT];
  assign rd_req         = addr_phase & ~HWRITE;
  assign wr_req         = addr_phase & HWRITE;
  assign req_win        = HADDR[13:12];
  assign req_ofs        = HADDR[11:0];
  // anything above the three windows is unmapped and reads as zero
  assign req_upper_zero = (HADDR[31:14] == 18'h00000);

  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wr_pend_r  <= 1'b0;
      wr_win_r   <= 2'h0;
      wr_ofs_r   <= 12'h000;
      wr_word_r  <= 1'b0;
      wr_hi_ok_r <= 1'b0;
    end else begin
      wr_pend_r  <= wr_req;
      wr_win_r   <= req_win;
      wr_ofs_r   <= req_ofs;
      // partial-word writes are taken as no-ops, not merged
      wr_word_r  <= (HSIZE == `HSIZE_WORD);
      wr_hi_ok_r <= req_upper_zero;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write strobes, live in the data phase

  wire wr_ok;
  wire wr_slave_side;
  wire wr_bridge;
  wire wr_status;
  wire we_read_prio;
  wire we_write_prio;
  wire we_issue;
  wire we_switch;
  wire we_cross_hit;
  wire we_cross;
  wire cross_bad_code;

  assign wr_ok         = wr_pend_r & wr_word_r & wr_hi_ok_r;
  assign wr_slave_side = wr_ok & (wr_win_r == `WIN_SLAVE_SIDE);
  assign wr_bridge     = wr_ok & (wr_win_r == `WIN_BRIDGE);
  assign wr_status     = wr_ok & (wr_win_r == `WIN_STATUS) &
                         (wr_ofs_r == `OFS_STATUS);

  // every other offset decodes to no strobe, so writes there vanish
  assign we_read_prio  = wr_slave_side & (wr_ofs_r == `OFS_READ_PRIO);  // RULE12
  assign we_write_prio = wr_slave_side & (wr_ofs_r == `OFS_WRITE_PRIO);
  assign we_issue      = wr_slave_side & (wr_ofs_r == `OFS_ISSUE_LIMIT);
  assign we_switch     = wr_bridge & (wr_ofs_r == `OFS_SWITCH_ISSUE);
  assign we_cross_hit  = wr_bridge & (wr_ofs_r == `OFS_CROSSING);

  // codes above async are refused so the crossing never sees them
  assign cross_bad_code = (HWDATA[`CROSS_W-1:0] > `CROSS_ASYNC);  // RULE11
  assign we_cross       = we_cross_hit & ~cross_bad_code;

  ////////////////////////////////////////////////////////////////////////////
  // slave-side interface block fields

  wire [`PRIO_W-1:0]  read_prio_nxt;
  wire [`PRIO_W-1:0]  write_prio_nxt;
  wire [`ISSUE_W-1:0] issue_nxt;
  wire [`ISSUE_W-1:0] issue_q;

  cfg_field_reg #(
    .W       (`PRIO_W),
    .RST     (READ_PRIO_RESET),                                   // RULE4
    .PRESENT (QOS_PROGRAMMABLE)                                   // RULE3
  ) u_read_prio (
    .clk     (SYS_CLK),
    .arst_n  (ARST_N),
    .wr_en   (we_read_prio),                                      // RULE1
    .wr_data (HWDATA[`PRIO_W-1:0]),
    .nxt     (read_prio_nxt),
    .q       (READ_PRIORITY_LEVEL)
  );

  cfg_field_reg #(
    .W       (`PRIO_W),
    .RST     (WRITE_PRIO_RESET),                                  // RULE4
    .PRESENT (QOS_PROGRAMMABLE)                                   // RULE3
  ) u_write_prio (
    .clk     (SYS_CLK),
    .arst_n  (ARST_N),
    .wr_en   (we_write_prio),                                     // RULE2
    .wr_data (HWDATA[`PRIO_W-1:0]),
    .nxt     (write_prio_nxt),
    .q       (WRITE_PRIORITY_LEVEL)
  );

  cfg_field_reg #(
    .W       (`ISSUE_W),
    .RST     (`ISSUE_RST),                                        // RULE6
    .PRESENT (1)
  ) u_issue (
    .clk     (SYS_CLK),
    .arst_n  (ARST_N),
    .wr_en   (we_issue),                                          // RULE5
    .wr_data (HWDATA[`ISSUE_W-1:0]),
    .nxt     (issue_nxt),
    .q       (issue_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // internal bridge block fields

  wire [`ISSUE_W-1:0] switch_nxt;
  wire [`ISSUE_W-1:0] switch_q;
  wire [`CROSS_W-1:0] cross_nxt;

  cfg_field_reg #(
    .W       (`ISSUE_W),
    .RST     (`ISSUE_RST),                                        // RULE8
    .PRESENT (1)
  ) u_switch (
    .clk     (SYS_CLK),
    .arst_n  (ARST_N),
    .wr_en   (we_switch),                                         // RULE7
    .wr_data (HWDATA[`ISSUE_W-1:0]),
    .nxt     (switch_nxt),
    .q       (switch_q)
  );

  cfg_field_reg #(
    .W       (`CROSS_W),
    .RST     (`CROSS_RST),                                        // RULE9
    .PRESENT (CROSSING_PROGRAMMABLE)                              // RULE9
  ) u_cross (
    .clk     (SYS_CLK),
    .arst_n  (ARST_N),
    .wr_en   (we_cross),
    .wr_data (HWDATA[`CROSS_W-1:0]),
    .nxt     (cross_nxt),
    .q       (CROSSING_SCHEME)
  );

  ////////////////////////////////////////////////////////////////////////////
  // override and crossing outputs, registered from the forwarded values

  reg  [4:0] cross_sel_nxt;
  wire       cross_sel_seed;
  wire       qos_seed;

  // build-time presence flags, also reported in the status word
  assign cross_sel_seed = (CROSSING_PROGRAMMABLE != 0);
  assign qos_seed       = (QOS_PROGRAMMABLE != 0);

  // an absent crossing register must not look like a 1:1 select, so the
  // one-hot is forced low rather than decoded from the zero field
  always @* begin
    cross_sel_nxt = 5'h00;
    if (cross_sel_seed) begin
      case (cross_nxt)
        `CROSS_SYNC_1_1: cross_sel_nxt = 5'h01;                   // RULE10
        `CROSS_SYNC_M_1: cross_sel_nxt = 5'h02;                   // RULE10
        `CROSS_SYNC_1_N: cross_sel_nxt = 5'h04;                   // RULE10
        `CROSS_SYNC_M_N: cross_sel_nxt = 5'h08;                   // RULE10
        `CROSS_ASYNC:    cross_sel_nxt = 5'h10;                   // RULE10
        default:         cross_sel_nxt = 5'h00;
      endcase
    end
  end

  // outputs follow the field value in the same cycle the field updates; the crossing select resets to zero and catches up one edge later
  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      READ_ISSUE_LIMIT         <= 1'b0;
      WRITE_ISSUE_LIMIT        <= 1'b0;
      SWITCH_READ_ISSUE_LIMIT  <= 1'b0;
      SWITCH_WRITE_ISSUE_LIMIT <= 1'b0;
      CROSSING_SEL             <= 5'h00;
    end else begin
      READ_ISSUE_LIMIT         <= issue_nxt[`ISSUE_RD_BIT];       // RULE6
      WRITE_ISSUE_LIMIT        <= issue_nxt[`ISSUE_WR_BIT];       // RULE6
      SWITCH_READ_ISSUE_LIMIT  <= switch_nxt[`ISSUE_RD_BIT];      // RULE8
      SWITCH_WRITE_ISSUE_LIMIT <= switch_nxt[`ISSUE_WR_BIT];      // RULE8
      CROSSING_SEL             <= cross_sel_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // block status: configuration and refused-code flag

  reg  reject_r;
  wire reject_nxt;
  wire reject_clr;

  assign reject_clr = wr_status & HWDATA[`STAT_REJECT_BIT];
  // a refusal in the clearing cycle still leaves the flag set
  assign reject_nxt = (we_cross_hit & cross_bad_code &
                       cross_sel_seed) | (reject_r & ~reject_clr);

  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      reject_r <= 1'b0;
    end else begin
      reject_r <= reject_nxt;
    end
  end

  wire [31:0] status_word;

  assign status_word = {29'h00000000,
                        reject_nxt,
                        cross_sel_seed,
                        qos_seed};

  ////////////////////////////////////////////////////////////////////////////
  // read mux
  // reads see the forwarded next values, so a read right behind a
  // write to the same field returns the new value with no wait state

  reg [31:0] rd_val;

  always @* begin
    rd_val = 32'h00000000;                                        // RULE12
    if (req_upper_zero) begin
      case (req_win)
        `WIN_SLAVE_SIDE: begin
          case (req_ofs)
            `OFS_READ_PRIO:   rd_val[`PRIO_W-1:0]  = read_prio_nxt;
            `OFS_WRITE_PRIO:  rd_val[`PRIO_W-1:0]  = write_prio_nxt;
            `OFS_ISSUE_LIMIT: rd_val[`ISSUE_W-1:0] = issue_nxt;
            default:          rd_val = 32'h00000000;
          endcase
        end
        `WIN_BRIDGE: begin
          case (req_ofs)
            `OFS_SWITCH_ISSUE: rd_val[`ISSUE_W-1:0] = switch_nxt;
            `OFS_CROSSING:     rd_val[`CROSS_W-1:0] = cross_nxt;
            default:           rd_val = 32'h00000000;
          endcase
        end
        `WIN_STATUS: begin
          if (req_ofs == `OFS_STATUS) begin
            rd_val = status_word;
          end
        end
        default: rd_val = 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // response: zero wait states, always okay

  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      HRDATA    <= 32'h00000000;
      HREADYOUT <= 1'b1;
      HRESP     <= `HRESP_OKAY;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP     <= `HRESP_OKAY;
      if (rd_req) begin
        HRDATA <= rd_val;
      end else begin
        HRDATA <= 32'h00000000;
      end
    end
  end

endmodule

// ---- shared/bridge_regs_consts.vh ----
// constants for the bridge control register bank
// assumes byte addresses on a 32-bit AHB-Lite bus, one word per register
`ifndef BRIDGE_REGS_CONSTS_VH
`define BRIDGE_REGS_CONSTS_VH

// address windows, selected by address bits 13:12
`define WIN_SLAVE_SIDE      2'h0
`define WIN_BRIDGE          2'h1
`define WIN_STATUS          2'h2

// slave-side interface block offsets
`define OFS_READ_PRIO       12'h100
`define OFS_WRITE_PRIO      12'h104
`define OFS_ISSUE_LIMIT     12'h108

// internal bridge block offsets
`define OFS_SWITCH_ISSUE    12'h008
`define OFS_CROSSING        12'h020

// block status window offset
`define OFS_STATUS          12'h000

// field widths
`define PRIO_W              4
`define ISSUE_W             2
`define CROSS_W             3

// reset values
`define PRIO_RST            4'h0
`define ISSUE_RST           2'h0
`define CROSS_RST           3'h4

// issuing override bit positions
`define ISSUE_RD_BIT        0
`define ISSUE_WR_BIT        1

// crossing scheme encodings
`define CROSS_SYNC_1_1      3'h0
`define CROSS_SYNC_M_1      3'h1
`define CROSS_SYNC_1_N      3'h2
`define CROSS_SYNC_M_N      3'h3
`define CROSS_ASYNC         3'h4

// status register bit positions
`define STAT_QOS_BIT        0
`define STAT_CROSS_BIT      1
`define STAT_REJECT_BIT     2

// ahb codes
`define HTRANS_NONSEQ_BIT   1
`define HSIZE_WORD          3'h2
`define HRESP_OKAY          1'h0

`endif

// ---- hw/cfg_field_reg.v ----
// one software-writable control field with forwarded next value
// assumes a single clock and an active-low asynchronous reset
`timescale 1ns/1ps

module cfg_field_reg #(
  parameter         W       = 4,
  parameter [W-1:0] RST     = {W{1'b0}},
  parameter         PRESENT = 1
) (
  // clock and reset
  input  wire         clk,
  input  wire         arst_n,
  // write side
  input  wire         wr_en,
  input  wire [W-1:0] wr_data,
  // field value
  output wire [W-1:0] nxt,
  output reg  [W-1:0] q
);

  // an absent field holds zero and ignores every write
  localparam [W-1:0] RVAL = (PRESENT != 0) ? RST : {W{1'b0}};

  ////////////////////////////////////////////////////////////////////////////
  assign nxt = ((PRESENT != 0) && wr_en) ? wr_data : q;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= RVAL;
    end else begin
      q <= nxt;
    end
  end

endmodule

// ---- sim/bridge_regs_checker.sv ----
// assertion checker for the bridge control register bank
// assumes it is bound to every bank instance and sees only its ports
`timescale 1ns/1ps
`include "bridge_regs_consts.vh"

module bridge_regs_checker #(
  parameter QOS   = 1,
  parameter CROSS = 1
) (
  // clock and reset
  input wire                SYS_CLK,
  input wire                ARST_N,
  // ahb-lite slave
  input wire                HSEL,
  input wire [31:0]         HADDR,
  input wire [1:0]          HTRANS,
  input wire                HWRITE,
  input wire [2:0]          HSIZE,
  input wire [31:0]         HWDATA,
  input wire                HREADY,
  input wire [31:0]         HRDATA,
  // control outputs
  input wire [`PRIO_W-1:0]  READ_PRIORITY_LEVEL,
  input wire [`PRIO_W-1:0]  WRITE_PRIORITY_LEVEL,
  input wire                READ_ISSUE_LIMIT,
  input wire                WRITE_ISSUE_LIMIT,
  input wire                SWITCH_READ_ISSUE_LIMIT,
  input wire                SWITCH_WRITE_ISSUE_LIMIT,
  input wire [`CROSS_W-1:0] CROSSING_SCHEME,
  input wire [4:0]          CROSSING_SEL
);
  reg        rd_r;
  reg        wr_r;
  reg [31:0] adr_r;
  wire       take;
  wire       known;

  assign take = HSEL & HREADY & HTRANS[1];
  // partial-size writes are refused, so they never count as data phases
  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rd_r  <= 1'b0;
      wr_r  <= 1'b0;
      adr_r <= 32'h0;
    end else begin
      rd_r  <= take & ~HWRITE;
      wr_r  <= take & HWRITE & (HSIZE == `HSIZE_WORD);
      adr_r <= HADDR;
    end
  end
  assign known = adr_r == 32'h100 || adr_r == 32'h104 ||
                 adr_r == 32'h108 || adr_r == 32'h1008 ||
                 adr_r == 32'h1020 || adr_r == 32'h2000;

  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);

  chk_rdprio_write: assert property (wr_r && adr_r == 32'h100 |=>
    {28'h0, READ_PRIORITY_LEVEL} == (QOS ? ($past(HWDATA) & 32'hf) : 32'h0))
    else $error("read priority not stored");
  chk_wrprio_write: assert property (wr_r && adr_r == 32'h104 |=>
    {28'h0, WRITE_PRIORITY_LEVEL} == (QOS ? ($past(HWDATA) & 32'hf) : 32'h0))
    else $error("write priority not stored");
  chk_issue_write: assert property (wr_r && adr_r == 32'h108 |=>
    {30'h0, WRITE_ISSUE_LIMIT, READ_ISSUE_LIMIT} == ($past(HWDATA) & 32'h3))
    else $error("issue override bits wrong");
  chk_switch_write: assert property (wr_r && adr_r == 32'h1008 |=>
    {30'h0, SWITCH_WRITE_ISSUE_LIMIT, SWITCH_READ_ISSUE_LIMIT} ==
    ($past(HWDATA) & 32'h3))
    else $error("switch override bits wrong");
  chk_cross_write: assert property (wr_r && adr_r == 32'h1020 &&
    HWDATA[2:0] < 3'h5 |=> {29'h0, CROSSING_SCHEME} ==
    (CROSS ? ($past(HWDATA) & 32'h7) : 32'h0))
    else $error("crossing code not stored");
  chk_cross_refuse: assert property (wr_r && adr_r == 32'h1020 &&
    HWDATA[2:0] > 3'h4 |=> $stable(CROSSING_SCHEME))
    else $error("reserved crossing code taken");
  // the select moves with the code but lags its reset value by one edge, so only settled codes count
  chk_cross_onehot: assert property ($past(ARST_N) &&
    $stable(CROSSING_SCHEME) |-> CROSSING_SEL ==
    (CROSS ? (5'h01 << CROSSING_SCHEME) : 5'h00))
    else $error("crossing select not one-hot of code");
  chk_cross_read: assert property (rd_r && adr_r == 32'h1020 |->
    HRDATA == {29'h0, CROSSING_SCHEME})
    else $error("crossing readback wrong");
  chk_reserved_zero: assert property (rd_r && !known |->
    HRDATA == 32'h0)
    else $error("reserved offset read nonzero");
endmodule

bind bridge_qos_issue_sync_regs bridge_regs_checker #(
  .QOS(QOS_PROGRAMMABLE), .CROSS(CROSSING_PROGRAMMABLE)
) chk (
  .SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .HSEL(HSEL), .HADDR(HADDR),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
  .HREADY(HREADY), .HRDATA(HRDATA),
  .READ_PRIORITY_LEVEL(READ_PRIORITY_LEVEL),
  .WRITE_PRIORITY_LEVEL(WRITE_PRIORITY_LEVEL),
  .READ_ISSUE_LIMIT(READ_ISSUE_LIMIT), .WRITE_ISSUE_LIMIT(WRITE_ISSUE_LIMIT),
  .SWITCH_READ_ISSUE_LIMIT(SWITCH_READ_ISSUE_LIMIT),
  .SWITCH_WRITE_ISSUE_LIMIT(SWITCH_WRITE_ISSUE_LIMIT),
  .CROSSING_SCHEME(CROSSING_SCHEME), .CROSSING_SEL(CROSSING_SEL));

// ---- sim/bridge_qos_issue_sync_regs_test.sv ----
// self-checking bench for the bridge control register bank
// assumes an always-ready slave; a second bank has priority and
// crossing registers absent
`timescale 1ns/1ps

module bridge_qos_issue_sync_regs_test;
  reg         SYS_CLK;
  reg         ARST_N;
  reg         HSEL;
  reg  [31:0] HADDR;
  reg  [1:0]  HTRANS;
  reg         HWRITE;
  reg  [2:0]  HSIZE;
  reg  [31:0] HWDATA;
  wire        HREADY;
  wire        hresp;
  wire [31:0] HRDATA;
  wire [31:0] rdata_nq;
  wire [3:0]  rprio, wprio, rprio_nq, wprio_nq;
  wire        rd_lim, wr_lim, sw_rd, sw_wr;
  wire [2:0]  scheme;
  wire [4:0]  sel;
  wire [2:0]  scheme_nq;
  wire [4:0]  sel_nq;
  integer     fail_count, cmp_count, cycles, i;
  reg  [31:0] rd, rd_nq;

  bridge_qos_issue_sync_regs #(
    .READ_PRIO_RESET(4'h9), .WRITE_PRIO_RESET(4'h6)
  ) uut (
    .SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
    .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADY), .HRESP(hresp),
    .READ_PRIORITY_LEVEL(rprio), .WRITE_PRIORITY_LEVEL(wprio),
    .READ_ISSUE_LIMIT(rd_lim), .WRITE_ISSUE_LIMIT(wr_lim),
    .SWITCH_READ_ISSUE_LIMIT(sw_rd), .SWITCH_WRITE_ISSUE_LIMIT(sw_wr),
    .CROSSING_SCHEME(scheme), .CROSSING_SEL(sel));
  // same bus, priority and crossing registers configured out
  bridge_qos_issue_sync_regs #(
    .QOS_PROGRAMMABLE(0), .READ_PRIO_RESET(4'h9), .CROSSING_PROGRAMMABLE(0)
  ) uut_nq (
    .SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
    .HREADY(HREADY), .HRDATA(rdata_nq), .HREADYOUT(), .HRESP(),
    .READ_PRIORITY_LEVEL(rprio_nq), .WRITE_PRIORITY_LEVEL(wprio_nq),
    .READ_ISSUE_LIMIT(), .WRITE_ISSUE_LIMIT(),
    .SWITCH_READ_ISSUE_LIMIT(), .SWITCH_WRITE_ISSUE_LIMIT(),
    .CROSSING_SCHEME(scheme_nq), .CROSSING_SEL(sel_nq));

  ////////////////////////////////////////////////////////////////////////
  task give_verdict;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  task chk(input string nm, input [31:0] exp, input [31:0] got);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("[ERR] %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask

  // one single transfer; read data is taken at the data-phase edge
  task bus(input [31:0] a, input w, input [31:0] d);
    begin
      HSEL   <= 1'b1;
      HTRANS <= 2'h2;
      HADDR  <= a;
      HWRITE <= w;
      @(posedge SYS_CLK);
      while (HREADY !== 1'b1) @(posedge SYS_CLK);
      HTRANS <= 2'h0;
      HWDATA <= d;
      @(posedge SYS_CLK);
      while (HREADY !== 1'b1) @(posedge SYS_CLK);
      rd    = HRDATA;
      rd_nq = rdata_nq;
    end
  endtask

  task rdchk(input [31:0] a, input [31:0] e);
    begin
      bus(a, 1'b0, 32'h0);
      chk($sformatf("read %h", a), e, rd);
    end
  endtask

  task wrrd(input [31:0] a, input [31:0] d, input [31:0] e);
    begin
      bus(a, 1'b1, d);
      rdchk(a, e);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    SYS_CLK = 1'b0;
    forever #20 SYS_CLK = ~SYS_CLK;
  end

  // nominal run is under 140 cycles
  always @(posedge SYS_CLK) begin
    cycles = cycles + 1;
    if (cycles == 2000) begin
      fail_count = fail_count + 1;
      give_verdict;
    end
  end

  initial begin
    fail_count = 0;
    cmp_count  = 0;
    cycles     = 0;
    ARST_N     = 1'b0;
    HSEL       = 1'b0;
    HADDR      = 32'h0;
    HTRANS     = 2'h0;
    HWRITE     = 1'b0;
    HSIZE      = 3'h2;
    HWDATA     = 32'h0;
    repeat (16) @(posedge SYS_CLK);
    ARST_N <= 1'b1;
    @(posedge SYS_CLK);
    rdchk(32'h100, 32'h9);
    chk("absent read prio", 32'h0, rd_nq);
    rdchk(32'h104, 32'h6);
    rdchk(32'h108, 32'h0);
    rdchk(32'h1008, 32'h0);
    rdchk(32'h1020, 32'h4);
    chk("absent crossing read", 32'h0, rd_nq);
    chk("crossing select reset", 32'h10, {27'h0, sel});
    chk("prio ports", 32'h96, {24'h0, rprio, wprio});
    $display("test reset values done");
    bus(32'h100, 1'b1, 32'hfffffffa);
    wrrd(32'h104, 32'h5, 32'h5);
    rdchk(32'h100, 32'ha);
    chk("absent ports", 32'h0, {24'h0, rprio_nq, wprio_nq});
    HSIZE <= 3'h0;
    bus(32'h100, 1'b1, 32'h3);
    HSIZE <= 3'h2;
    rdchk(32'h100, 32'ha);
    for (i = 0; i < 4; i = i + 1) begin
      wrrd(32'h108, i, i);
      chk("issue ports", i, {30'h0, wr_lim, rd_lim});
      wrrd(32'h1008, i, i);
      chk("switch ports", i, {30'h0, sw_wr, sw_rd});
    end
    $display("test field access done");
    for (i = 0; i < 5; i = i + 1) begin
      wrrd(32'h1020, i, i);
      chk("crossing select", 32'h1 << i, {27'h0, sel});
    end
    for (i = 5; i < 8; i = i + 1)
      wrrd(32'h1020, i, 32'h4);
    chk("crossing port", 32'h4, {29'h0, scheme});
    chk("absent cross ports", 32'h0, {24'h0, sel_nq, scheme_nq});
    rdchk(32'h2000, 32'h7);
    chk("absent status", 32'h0, rd_nq);
    bus(32'h2000, 1'b1, 32'h4);
    rdchk(32'h2000, 32'h3);
    $display("test crossing codes done");
    wrrd(32'h10c, 32'hffffffff, 32'h0);
    wrrd(32'h114, 32'hffffffff, 32'h0);
    wrrd(32'hffc, 32'hffffffff, 32'h0);
    wrrd(32'h1000, 32'hffffffff, 32'h0);
    wrrd(32'h100c, 32'hffffffff, 32'h0);
    wrrd(32'h3000, 32'hffffffff, 32'h0);
    rdchk(32'h108, 32'h3);
    rdchk(32'h1008, 32'h3);
    chk("response", 32'h0, {31'h0, hresp});
    $display("test reserved offsets done");
    give_verdict;
  end
endmodule
